// ---- logic/pmc_pkg.sv ----
// Constants and types for the program memory and configuration loader
`default_nettype none
package pmc_pkg;
  typedef logic [20:0] pmc_addr_t;
  typedef logic [15:0] pmc_word_t;
  localparam pmc_addr_t RESET_VEC = 21'h000000;
  localparam pmc_addr_t HI_VEC = 21'h000008;
  localparam pmc_addr_t LO_VEC = 21'h000018;
  localparam pmc_addr_t PC_STEP = 21'h000002;
  localparam pmc_addr_t TOP_64K = 21'h010000;
  localparam pmc_addr_t TOP_96K = 21'h018000;
  localparam pmc_addr_t TOP_128K = 21'h020000;
  localparam pmc_addr_t CFG_SPAN = 21'h000008;
  localparam logic [1:0] CFG_FIRST = 2'h0;
  localparam logic [1:0] CFG_LAST = 2'h2;
  localparam logic [1:0] CFG_STEP = 2'h1;
  localparam pmc_word_t NOP_WORD = 16'h0000;
  localparam logic [4:0] SP_RESET = 5'h00;
  localparam logic [4:0] SP_STEP = 5'h01;
  typedef enum logic [1:0] {SEL_64K, SEL_96K, SEL_128K} pmc_size_t;
  typedef enum logic [1:0] {ST_LOAD, ST_CAPT, ST_RUN} pmc_mode_t;
  typedef struct packed {
    logic [4:0] upper;
    logic [7:0] high;
    logic [7:0] low;
  } pmc_tos_t;
  typedef struct packed {
    pmc_word_t third;
    pmc_word_t second;
    pmc_word_t first;
  } pmc_cfg_t;
  typedef struct packed {
    logic high;
    logic low;
  } pmc_flags_t;
  typedef struct packed {
    pmc_mode_t mode;
    pmc_addr_t pc;
    logic [1:0] cfg_idx;
    pmc_cfg_t cfg;
    logic cfg_done;
    pmc_tos_t tos;
    logic [4:0] sp;
    logic pend;
    logic over;
    logic valid;
    pmc_word_t data;
    pmc_flags_t flags;
  } pmc_state_t;
  function automatic pmc_addr_t top_of(input pmc_size_t sel);
    case (sel)
      SEL_64K: top_of = TOP_64K;
      SEL_96K: top_of = TOP_96K;
      default: top_of = TOP_128K;
    endcase
  endfunction
endpackage
`default_nettype wire

// ---- logic/pmc_loader.sv ----
// Program memory map, configuration load and interrupt wake-up vectoring
// What this block does
// - Program counter is 21 bits wide
// - Reads above implemented flash return zero
// - Every reset loads program counter with zero
// - Interrupt vectors fixed at 0x0008 and 0x0018
// - Top four flash words hold configuration
// - Each reset copies configuration into registers
// - Configuration bytes stored low byte first, ascending
// - Only first three words used; fourth ignored
// - Configuration range follows the flash size
// - Flash size 64, 96 or 128 Kbytes
// - Enabled wake pushes PC, advances stack pointer
// - Enabled wake loads matching priority vector
// - Wake leaves interrupt flag bits set
// - Fetch path separate from data RAM
`default_nettype none
module pmc_loader #(
  parameter pmc_pkg::pmc_size_t FLASH_SIZE = pmc_pkg::SEL_128K
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic fetch_req_in,
  output logic fetch_ready_out,
  output logic fetch_valid_out,
  output pmc_pkg::pmc_word_t fetch_data_out,
  output pmc_pkg::pmc_addr_t pc_out,
  output logic flash_rd_out,
  output pmc_pkg::pmc_addr_t flash_addr_out,
  input wire pmc_pkg::pmc_word_t flash_rdata_in,
  input wire logic wake_in,
  input wire logic wake_high_in,
  input wire logic high_priority_global_irq_enable_in,
  input wire logic low_priority_global_irq_enable_in,
  input wire pmc_pkg::pmc_flags_t flag_clear_in,
  output pmc_pkg::pmc_flags_t interrupt_control_regs_out,
  output pmc_pkg::pmc_tos_t stack_top_out,
  output logic [4:0] return_stack_pointer_out,
  output pmc_pkg::pmc_cfg_t config_out,
  output logic cfg_done_out
);
  localparam pmc_pkg::pmc_addr_t TOP = pmc_pkg::top_of(FLASH_SIZE);
  localparam pmc_pkg::pmc_addr_t CFG_BASE = TOP - pmc_pkg::CFG_SPAN;

  pmc_pkg::pmc_state_t state;
  pmc_pkg::pmc_state_t next_state;
  logic run;
  logic wake_go;
  logic fetch_go;
  logic in_range;
  pmc_pkg::pmc_addr_t cfg_addr;

  always_comb begin
    run = (state.mode == pmc_pkg::ST_RUN);
    wake_go = run && wake_in &&
      (high_priority_global_irq_enable_in || low_priority_global_irq_enable_in);
    fetch_go = run && fetch_req_in && !wake_go;
    in_range = (state.pc < TOP);
    cfg_addr = CFG_BASE + {18'h00000, state.cfg_idx, 1'b0};
  end

  // Flash is read by the configuration load, then by the fetch port; data RAM sits on its own bus
  always_comb begin
    fetch_ready_out = run && !wake_go;
    flash_rd_out = 1'b0;
    flash_addr_out = pmc_pkg::RESET_VEC;
    if (state.mode == pmc_pkg::ST_LOAD) begin
      flash_rd_out = 1'b1;
      flash_addr_out = cfg_addr;
    end else if (fetch_go && in_range) begin
      flash_rd_out = 1'b1;
      flash_addr_out = state.pc;
    end
  end

  always_comb begin
    next_state = state;
    next_state.valid = state.pend;
    next_state.pend = 1'b0;
    if (state.pend) begin
      next_state.data = state.over ? pmc_pkg::NOP_WORD : flash_rdata_in;
    end
    case (state.mode)
      pmc_pkg::ST_LOAD: begin
        next_state.mode = pmc_pkg::ST_CAPT;
      end
      pmc_pkg::ST_CAPT: begin
        case (state.cfg_idx)
          pmc_pkg::CFG_FIRST: next_state.cfg.first = flash_rdata_in;
          pmc_pkg::CFG_LAST: next_state.cfg.third = flash_rdata_in;
          default: next_state.cfg.second = flash_rdata_in;
        endcase
        if (state.cfg_idx == pmc_pkg::CFG_LAST) begin
          next_state.mode = pmc_pkg::ST_RUN;
          next_state.cfg_done = 1'b1;
        end else begin
          next_state.cfg_idx = state.cfg_idx + pmc_pkg::CFG_STEP;
          next_state.mode = pmc_pkg::ST_LOAD;
        end
      end
      pmc_pkg::ST_RUN: begin
        if (wake_go) begin
          next_state.tos = state.pc;
          next_state.sp = state.sp + pmc_pkg::SP_STEP;
          next_state.pc = wake_high_in ? pmc_pkg::HI_VEC : pmc_pkg::LO_VEC;
        end else if (fetch_go) begin
          next_state.pend = 1'b1;
          next_state.over = !in_range;
          next_state.pc = state.pc + pmc_pkg::PC_STEP;
        end
      end
      default: next_state.mode = pmc_pkg::ST_LOAD;
    endcase
    // Set beats clear in the same cycle
    next_state.flags.high = (state.flags.high && !flag_clear_in.high) ||
      (wake_in && wake_high_in);
    next_state.flags.low = (state.flags.low && !flag_clear_in.low) ||
      (wake_in && !wake_high_in);
    if (!reset_n_in) begin
      next_state = '0;
      next_state.mode = pmc_pkg::ST_LOAD;
      next_state.pc = pmc_pkg::RESET_VEC;
      next_state.sp = pmc_pkg::SP_RESET;
    end
  end

  always_ff @(posedge clock_in) begin
    state <= next_state;
  end

  always_comb begin
    fetch_valid_out = state.valid;
    fetch_data_out = state.data;
    pc_out = state.pc;
    interrupt_control_regs_out = state.flags;
    stack_top_out = state.tos;
    return_stack_pointer_out = state.sp;
    config_out = state.cfg;
    cfg_done_out = state.cfg_done;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  a_reset_vector_pc: assert property ($rose(reset_n_in) |-> pc_out == pmc_pkg::RESET_VEC)
    else $error("PC not at reset vector after reset");
  a_beyond_reads_zero: assert property (fetch_go && !in_range |-> ##2
    (fetch_valid_out && fetch_data_out == pmc_pkg::NOP_WORD))
    else $error("Read above flash did not return zero");
  a_fetch_data_path: assert property (fetch_go && in_range |=>
    ##1 (fetch_valid_out && fetch_data_out == $past(flash_rdata_in)))
    else $error("Fetched word not returned two cycles later");
  a_pc_step_two: assert property (fetch_go |=> pc_out == $past(pc_out) + pmc_pkg::PC_STEP)
    else $error("PC did not advance by one word");
  a_high_vector_load: assert property (wake_go && wake_high_in |=> pc_out == pmc_pkg::HI_VEC)
    else $error("High priority vector not loaded");
  a_low_vector_load: assert property (wake_go && !wake_high_in |=> pc_out == pmc_pkg::LO_VEC)
    else $error("Low priority vector not loaded");
  a_wake_push_stack: assert property (wake_go |=> stack_top_out == $past(pc_out) &&
    return_stack_pointer_out == $past(return_stack_pointer_out) + pmc_pkg::SP_STEP)
    else $error("Wake did not push PC onto stack");
  a_wake_sets_flag: assert property (wake_in |=>
    (interrupt_control_regs_out.high || interrupt_control_regs_out.low))
    else $error("Wake left no interrupt flag set");
  a_cfg_read_range: assert property (flash_rd_out && !run |->
    (flash_addr_out >= CFG_BASE && flash_addr_out < TOP - pmc_pkg::PC_STEP))
    else $error("Configuration read outside used top words");
  a_cfg_before_fetch: assert property (fetch_valid_out || fetch_ready_out |-> cfg_done_out)
    else $error("Fetch before configuration loaded");
  a_cfg_load_time: assert property ($rose(reset_n_in) |-> ##6 $rose(cfg_done_out))
    else $error("Configuration load did not finish in six cycles");

  // Flag, fetch, wake, reset and configuration guards
  a_flag_set_wins: assert property (wake_in && wake_high_in && flag_clear_in.high |=>
    interrupt_control_regs_out.high)
    else $error("Clear beat a wake on the high flag");
  a_flag_clear_high: assert property (flag_clear_in.high && !wake_in |=>
    !interrupt_control_regs_out.high)
    else $error("High flag not cleared");
  a_quiet_wake_keeps: assert property (wake_in && !wake_go && !fetch_go |=>
    pc_out == $past(pc_out) && return_stack_pointer_out == $past(return_stack_pointer_out))
    else $error("Wake without enable moved PC or stack");
  a_valid_from_fetch: assert property (fetch_valid_out |->
    $past(fetch_go, 2))
    else $error("Fetch valid without a fetch two cycles earlier");
  a_beyond_no_read: assert property (fetch_go && !in_range |->
    !flash_rd_out)
    else $error("Flash read above implemented memory");
  a_fetch_addr_pc: assert property (fetch_go && in_range |->
    flash_rd_out && flash_addr_out == pc_out)
    else $error("Flash read not at the PC");
  a_data_stands: assert property (!fetch_valid_out |->
    $stable(fetch_data_out))
    else $error("Fetch data changed without valid");
  a_cfg_stands: assert property (cfg_done_out |=>
    $stable(config_out))
    else $error("Configuration changed after load");
  a_cfg_done_holds: assert property (cfg_done_out |=>
    cfg_done_out)
    else $error("Configuration done dropped without reset");
  a_wake_blocks_fetch: assert property (wake_go |->
    !fetch_ready_out && !flash_rd_out)
    else $error("Fetch accepted during enabled wake");
  a_reset_clears: assert property ($rose(reset_n_in) |->
    !cfg_done_out && !fetch_valid_out && return_stack_pointer_out == pmc_pkg::SP_RESET)
    else $error("State not cleared by reset");
  a_low_flag_set: assert property (wake_in && !wake_high_in |=>
    interrupt_control_regs_out.low)
    else $error("Low priority wake left low flag clear");
  a_cfg_first_addr: assert property ($rose(reset_n_in) |->
    flash_rd_out && flash_addr_out == CFG_BASE)
    else $error("First configuration read not at base");
  a_cfg_first_word: assert property (state.mode == pmc_pkg::ST_CAPT &&
    state.cfg_idx == pmc_pkg::CFG_FIRST |=> config_out.first == $past(flash_rdata_in))
    else $error("First configuration word not captured");

  c_cfg_loaded: cover property ($rose(cfg_done_out));
  c_high_wake: cover property (wake_go && wake_high_in);
  c_low_wake: cover property (wake_go && !wake_high_in);
  c_beyond_fetch: cover property (fetch_go && !in_range);
  c_flag_set_wins: cover property (wake_in && wake_high_in && flag_clear_in.high);
endmodule
`default_nettype wire

// ---- tb/pmc_flash_model.sv ----
// Flash array model for the loader's reads
`default_nettype none
module pmc_flash_model (
  input wire logic clock_in,
  input wire logic rd_in,
  input wire pmc_pkg::pmc_addr_t addr_in,
  output logic [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rdata_out = 16'hC3C3;
  // Word from address, one cycle later; scrambled when idle
  always @(posedge clock_in) begin
    if (rd_in) begin
      rdata_out <= addr_in[16:1] ^ 16'h5A5A;
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the program memory loader
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam pmc_pkg::pmc_addr_t TOP = 21'h010000;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic req = 1'b0, wk = 1'b0, wk_hi = 1'b0, en_h = 1'b0, en_l = 1'b0;
  pmc_pkg::pmc_flags_t clr = 2'h0;
  logic ready, valid, rd, done;
  logic [15:0] data, rdata;
  pmc_pkg::pmc_addr_t pc, faddr;
  pmc_pkg::pmc_flags_t flags;
  pmc_pkg::pmc_tos_t tos;
  logic [4:0] sp;
  pmc_pkg::pmc_cfg_t cfg;
  int fails = 0, tests_run = 0, cycles = 0;
  pmc_pkg::pmc_addr_t rd_log[$];
  pmc_loader #(.FLASH_SIZE(pmc_pkg::SEL_64K)) dut (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .fetch_req_in(req), .fetch_ready_out(ready),
    .fetch_valid_out(valid), .fetch_data_out(data), .pc_out(pc), .flash_rd_out(rd),
    .flash_addr_out(faddr), .flash_rdata_in(rdata), .wake_in(wk), .wake_high_in(wk_hi),
    .high_priority_global_irq_enable_in(en_h), .low_priority_global_irq_enable_in(en_l),
    .flag_clear_in(clr), .interrupt_control_regs_out(flags), .stack_top_out(tos),
    .return_stack_pointer_out(sp), .config_out(cfg), .cfg_done_out(done));
  pmc_flash_model flash (.clock_in(clock_in), .rd_in(rd), .addr_in(faddr),
    .rdata_out(rdata));
  initial forever #2.5 clock_in = ~clock_in;
  function automatic logic [15:0] word_at(input pmc_pkg::pmc_addr_t a);
    return a[16:1] ^ 16'h5A5A;
  endfunction
  task chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (rd && reset_n_in) rd_log.push_back(faddr);
    if (cycles == 80000) begin
      fails++;
      results();
    end
  end
  task t_reset;
    int n;
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    req <= 1'b0;
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd_log.delete();
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk(n, 6);
    chk(pc, pmc_pkg::RESET_VEC);
    chk(rd_log.size(), 3);
    for (int i = 0; i < 3; i++) chk(rd_log[i], TOP - 21'h8 + 21'(2 * i));
    chk(cfg, {word_at(TOP - 21'h4), word_at(TOP - 21'h6), word_at(TOP - 21'h8)});
    chk({flags, sp}, 7'h00);
    $display("test reset done");
  endtask
  task fetch_one(input logic hit);
    pmc_pkg::pmc_addr_t a;
    @(posedge clock_in);
    req <= 1'b1;
    #1;
    a = pc;
    chk({ready, rd}, {1'b1, hit});
    if (hit) chk(faddr, a);
    @(posedge clock_in);
    req <= 1'b0;
    #1;
    chk(pc, a + pmc_pkg::PC_STEP);
    @(posedge clock_in);
    #1;
    chk({valid, data}, {1'b1, hit ? word_at(a) : pmc_pkg::NOP_WORD});
  endtask
  task wake_one(input logic hi, input logic eh, input logic el, input pmc_pkg::pmc_addr_t vec);
    pmc_pkg::pmc_addr_t a;
    logic [4:0] s;
    @(posedge clock_in);
    wk <= 1'b1;
    wk_hi <= hi;
    en_h <= eh;
    en_l <= el;
    #1;
    a = pc;
    s = sp;
    chk(ready, !(eh || el));
    @(posedge clock_in);
    wk <= 1'b0;
    #1;
    chk(pc, (eh || el) ? vec : a);
    if (eh || el) chk(tos, a);
    chk(sp, s + {4'h0, eh | el});
    chk(hi ? flags.high : flags.low, 1'b1);
  endtask
  task t_fetch;
    repeat (3) fetch_one(1'b1);
    $display("test fetch done");
  endtask
  task clear_flags;
    @(posedge clock_in);
    clr <= 2'h3;
    @(posedge clock_in);
    clr <= 2'h0;
    #1;
    chk(flags, 2'h0);
  endtask
  task t_wake;
    wake_one(1'b1, 1'b1, 1'b0, pmc_pkg::HI_VEC);
    wake_one(1'b0, 1'b0, 1'b1, pmc_pkg::LO_VEC);
    clear_flags();
    wake_one(1'b1, 1'b0, 1'b0, pmc_pkg::HI_VEC);
    chk(flags, 2'h2);
    @(posedge clock_in);
    wk <= 1'b1;
    wk_hi <= 1'b1;
    clr <= 2'h3;
    @(posedge clock_in);
    wk <= 1'b0;
    clr <= 2'h0;
    #1;
    chk(flags, 2'h2);
    clear_flags();
    $display("test wake done");
  endtask
  task t_top;
    int n;
    @(posedge clock_in);
    req <= 1'b1;
    n = 0;
    while (pc < TOP && n < 40000) begin
      @(posedge clock_in);
      n++;
    end
    req <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk(pc[20:16], 5'h01);
    fetch_one(1'b0);
    fetch_one(1'b0);
    $display("test top done");
  endtask
  initial begin
    t_reset();
    t_fetch();
    t_wake();
    t_top();
    t_reset();
    results();
  end
endmodule
`default_nettype wire
